// file: rtl/ccrx_channel_regs.sv
// One channel's configuration registers and cross-point source choice.
// Assumes register strobes and shared control bits come from sys_clk logic;
// the two select pins arrive asynchronously from the board.
module ccrx_channel_regs #(
  parameter int unsigned CHAN_INDEX = 0
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       regs_reset,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic       pin_ctrl_enable,
  input  wire logic       output_source_select,
  input  wire logic       eq_bias_ext_msb,
  input  wire logic       select_pin_a,
  input  wire logic       select_pin_b,
  output logic            route_from_adjacent,
  output logic            xpoint_select_polarity_invert,
  output logic            eq_bias_small_boost,
  output logic            quick_detect_enable,
  output logic      [1:0] detect_threshold,
  output logic      [2:0] eq_bias_extra_current,
  output logic      [1:0] predriver_bias_extra,
  output logic      [1:0] output_driver_bias_extra
);

  // Channels 0,1,4,5 have bit 1 of the index clear
  localparam logic USES_PIN_A = (CHAN_INDEX[1] == 1'b0);

  // Named configuration registers
  logic [7:0] polarity_reg;
  logic [7:0] polarity_next;
  logic [7:0] bias_small_reg;
  logic [7:0] bias_small_next;
  logic [7:0] detect_reg;
  logic [7:0] detect_next;
  logic [7:0] bias_trim_reg;
  logic [7:0] bias_trim_next;

  // Select pin synchronisers and debounced levels
  logic [2:0] pin_a_sync_reg;
  logic [2:0] pin_a_sync_next;
  logic [2:0] pin_b_sync_reg;
  logic [2:0] pin_b_sync_next;
  logic       pin_a_level_reg;
  logic       pin_a_level_next;
  logic       pin_b_level_reg;
  logic       pin_b_level_next;

  // Derived outputs
  logic       route_reg;
  logic       route_next;
  logic [2:0] eq_bias_reg;
  logic [2:0] eq_bias_next;

  // Read pipeline
  logic       rd_pend_reg;
  logic       rd_pend_next;
  logic       rd_spare_reg;
  logic       rd_spare_next;
  logic [7:0] rd_named_reg;
  logic [7:0] rd_named_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;
  logic [7:0] mem_rdata;
  logic       sel_pin;

  ccrx_spare_mem u_spare (
    .sys_clk (sys_clk),
    .rst     (rst),
    .clear   (regs_reset),
    .wr_en   (reg_wr),
    .addr    (reg_addr),
    .wdata   (reg_wdata),
    .rdata   (mem_rdata)
  );

  // Register writes; channel reset returns every field to default
  always_comb begin
    polarity_next   = polarity_reg;
    bias_small_next = bias_small_reg;
    detect_next     = detect_reg;
    bias_trim_next  = bias_trim_reg;
    if (regs_reset) begin
      polarity_next   = ccrx_pkg::RST_POLARITY;
      bias_small_next = ccrx_pkg::RST_BIAS_SMALL;
      detect_next     = ccrx_pkg::RST_DETECT;
      bias_trim_next  = ccrx_pkg::RST_BIAS_TRIM;
    end else if (reg_wr) begin
      case (reg_addr)
        ccrx_pkg::ADDR_POLARITY:   polarity_next   = reg_wdata;
        ccrx_pkg::ADDR_BIAS_SMALL: bias_small_next = reg_wdata;
        ccrx_pkg::ADDR_DETECT:     detect_next     = reg_wdata;
        ccrx_pkg::ADDR_BIAS_TRIM:  bias_trim_next  = reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      polarity_reg   <= ccrx_pkg::RST_POLARITY;
      bias_small_reg <= ccrx_pkg::RST_BIAS_SMALL;
      detect_reg     <= ccrx_pkg::RST_DETECT;
      bias_trim_reg  <= ccrx_pkg::RST_BIAS_TRIM;
    end else begin
      polarity_reg   <= polarity_next;
      bias_small_reg <= bias_small_next;
      detect_reg     <= detect_next;
      bias_trim_reg  <= bias_trim_next;
    end
  end

  // Pin level accepted only when second and third stages agree
  always_comb begin
    pin_a_sync_next  = {pin_a_sync_reg[1:0], select_pin_a};
    pin_b_sync_next  = {pin_b_sync_reg[1:0], select_pin_b};
    pin_a_level_next = pin_a_level_reg;
    pin_b_level_next = pin_b_level_reg;
    if (pin_a_sync_reg[1] == pin_a_sync_reg[2]) begin
      pin_a_level_next = pin_a_sync_reg[2];
    end
    if (pin_b_sync_reg[1] == pin_b_sync_reg[2]) begin
      pin_b_level_next = pin_b_sync_reg[2];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_a_sync_reg  <= 3'h0;
      pin_b_sync_reg  <= 3'h0;
      pin_a_level_reg <= 1'b0;
      pin_b_level_reg <= 1'b0;
    end else begin
      pin_a_sync_reg  <= pin_a_sync_next;
      pin_b_sync_reg  <= pin_b_sync_next;
      pin_a_level_reg <= pin_a_level_next;
      pin_b_level_reg <= pin_b_level_next;
    end
  end

  // Cross-point source and bias composition
  assign sel_pin = USES_PIN_A ? pin_a_level_reg
                              : pin_b_level_reg;

  always_comb begin
    if (pin_ctrl_enable) begin
      route_next = sel_pin ^ polarity_reg[ccrx_pkg::BIT_POL_INVERT];
    end else begin
      route_next = output_source_select;
    end
    eq_bias_next = {eq_bias_ext_msb,
                    bias_trim_reg[ccrx_pkg::BIT_EQB_HI],
                    bias_trim_reg[ccrx_pkg::BIT_EQB_LO]};
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      route_reg   <= 1'b0;
      eq_bias_reg <= 3'h0;
    end else begin
      route_reg   <= route_next;
      eq_bias_reg <= eq_bias_next;
    end
  end

  // Two-stage read: select, then merge with spare memory data
  always_comb begin
    rd_pend_next  = reg_rd;
    rd_spare_next = ccrx_pkg::is_spare(reg_addr);
    case (reg_addr)
      ccrx_pkg::ADDR_POLARITY:   rd_named_next = polarity_reg;
      ccrx_pkg::ADDR_BIAS_SMALL: rd_named_next = bias_small_reg;
      ccrx_pkg::ADDR_DETECT:     rd_named_next = detect_reg;
      ccrx_pkg::ADDR_BIAS_TRIM:  rd_named_next = bias_trim_reg;
      default:                   rd_named_next = ccrx_pkg::RDATA_UNMAPPED;
    endcase
    rvalid_next = rd_pend_reg;
    rdata_next  = rdata_reg;
    if (rd_pend_reg) begin
      rdata_next = rd_spare_reg ? mem_rdata : rd_named_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_pend_reg  <= 1'b0;
      rd_spare_reg <= 1'b0;
      rd_named_reg <= ccrx_pkg::RDATA_UNMAPPED;
      rdata_reg    <= ccrx_pkg::RDATA_UNMAPPED;
      rvalid_reg   <= 1'b0;
    end else begin
      rd_pend_reg  <= rd_pend_next;
      rd_spare_reg <= rd_spare_next;
      rd_named_reg <= rd_named_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
    end
  end

  assign reg_rdata                     = rdata_reg;
  assign reg_rvalid                    = rvalid_reg;
  assign route_from_adjacent           = route_reg;
  assign xpoint_select_polarity_invert =
    polarity_reg[ccrx_pkg::BIT_POL_INVERT];
  assign eq_bias_small_boost = bias_small_reg[ccrx_pkg::BIT_SMALL_BOOST];
  assign quick_detect_enable = detect_reg[ccrx_pkg::BIT_QUICK_DET];
  assign detect_threshold    = {detect_reg[ccrx_pkg::BIT_THR_HI],
                                detect_reg[ccrx_pkg::BIT_THR_LO]};
  assign eq_bias_extra_current    = eq_bias_reg;
  assign predriver_bias_extra     = {bias_trim_reg[ccrx_pkg::BIT_PDRV_HI],
                                     bias_trim_reg[ccrx_pkg::BIT_PDRV_LO]};
  assign output_driver_bias_extra = {bias_trim_reg[ccrx_pkg::BIT_ODRV_HI],
                                     bias_trim_reg[ccrx_pkg::BIT_ODRV_LO]};

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_reg_ctrl_route;
    !pin_ctrl_enable |=> route_from_adjacent == $past(output_source_select);
  endproperty
  a_reg_ctrl_route: assert property (p_reg_ctrl_route)
    else $error("register control route mismatch");

  property p_invert_ignored;
    !pin_ctrl_enable && xpoint_select_polarity_invert && !output_source_select
      |=> !route_from_adjacent;
  endproperty
  a_invert_ignored: assert property (p_invert_ignored)
    else $error("invert acted without pin control");

  property p_pin_group;
    pin_ctrl_enable |=> route_from_adjacent ==
      ($past(USES_PIN_A ? pin_a_level_reg : pin_b_level_reg) ^
       $past(xpoint_select_polarity_invert));
  endproperty
  a_pin_group: assert property (p_pin_group)
    else $error("pin control used wrong select pin");

  property p_pin_mode_sel;
    pin_ctrl_enable && (USES_PIN_A ? pin_b_level_reg : pin_a_level_reg) !=
      sel_pin |=> route_from_adjacent ==
      ($past(sel_pin) ^ $past(xpoint_select_polarity_invert));
  endproperty
  a_pin_mode_sel: assert property (p_pin_mode_sel)
    else $error("route followed the other select pin");

  property p_plain_polarity;
    pin_ctrl_enable && !xpoint_select_polarity_invert
      |=> route_from_adjacent == $past(sel_pin);
  endproperty
  a_plain_polarity: assert property (p_plain_polarity)
    else $error("uninverted pin polarity wrong");

  property p_inv_polarity;
    pin_ctrl_enable && xpoint_select_polarity_invert
      |=> route_from_adjacent == !$past(sel_pin);
  endproperty
  a_inv_polarity: assert property (p_inv_polarity)
    else $error("inverted pin polarity wrong");

  property p_boost_write;
    reg_wr && !regs_reset && reg_addr == ccrx_pkg::ADDR_BIAS_SMALL
      |=> eq_bias_small_boost == $past(reg_wdata[ccrx_pkg::BIT_SMALL_BOOST]);
  endproperty
  a_boost_write: assert property (p_boost_write)
    else $error("small boost bit not written");

  property p_quick_write;
    reg_wr && !regs_reset && reg_addr == ccrx_pkg::ADDR_DETECT
      |=> quick_detect_enable == $past(reg_wdata[ccrx_pkg::BIT_QUICK_DET]);
  endproperty
  a_quick_write: assert property (p_quick_write)
    else $error("quick detect bit not written");

  property p_thr_reset;
    regs_reset |=> detect_threshold == 2'h3 && !quick_detect_enable;
  endproperty
  a_thr_reset: assert property (p_thr_reset)
    else $error("detect field default wrong");

  property p_eq_bias;
    1'b1 |=> eq_bias_extra_current[2] == $past(eq_bias_ext_msb);
  endproperty
  a_eq_bias: assert property (p_eq_bias)
    else $error("equalizer bias msb not joined");

  property p_drv_fields;
    reg_wr && !regs_reset && reg_addr == ccrx_pkg::ADDR_BIAS_TRIM |=>
      predriver_bias_extra == $past(reg_wdata[3:2]) &&
      output_driver_bias_extra == $past(reg_wdata[1:0]);
  endproperty
  a_drv_fields: assert property (p_drv_fields)
    else $error("driver bias fields not written");

  // Low bits reach the joined field one cycle after the register
  sequence s_trim_write;
    reg_wr && !regs_reset && reg_addr == ccrx_pkg::ADDR_BIAS_TRIM;
  endsequence
  property p_eq_lsbs;
    s_trim_write |-> ##2
      eq_bias_extra_current[1:0] == $past(reg_wdata[5:4], 2);
  endproperty
  a_eq_lsbs: assert property (p_eq_lsbs)
    else $error("equalizer bias low bits not joined");

  property p_low_write_ignored;
    reg_wr && !regs_reset && reg_addr < ccrx_pkg::ADDR_POLARITY
      |=> $stable(eq_bias_small_boost) && $stable(detect_threshold) &&
          $stable(predriver_bias_extra) && $stable(quick_detect_enable);
  endproperty
  a_low_write_ignored: assert property (p_low_write_ignored)
    else $error("write below mapped range took effect");

  sequence s_read_issue;
    reg_rd;
  endsequence
  sequence s_read_answer;
    !reg_rvalid ##1 reg_rvalid;
  endsequence
  property p_read_latency;
    s_read_issue ##1 !reg_rd |-> s_read_answer;
  endproperty
  a_read_latency: assert property (p_read_latency)
    else $error("read answer not two cycles after request");

endmodule // ccrx_channel_regs

// file: rtl/ccrx_pkg.sv
// Constants for one channel's cross-point and bias configuration slice.
// Assumes an 8-bit register access port with 5-bit channel offsets.
package ccrx_pkg;

  localparam logic [4:0] ADDR_POLARITY    = 5'h07;
  localparam logic [4:0] ADDR_BIAS_SMALL  = 5'h08;
  localparam logic [4:0] ADDR_SPARE_A     = 5'h09;
  localparam logic [4:0] ADDR_DETECT      = 5'h0A;
  localparam logic [4:0] ADDR_SPARE_B     = 5'h0B;
  localparam logic [4:0] ADDR_SPARE_C     = 5'h0C;
  localparam logic [4:0] ADDR_SPARE_E     = 5'h0E;
  localparam logic [4:0] ADDR_BIAS_TRIM   = 5'h0F;
  localparam logic [4:0] ADDR_SPARE_F     = 5'h10;
  localparam logic [4:0] ADDR_BLOCK_G_LO  = 5'h11;
  localparam logic [4:0] ADDR_BLOCK_H_HI  = 5'h1F;

  localparam logic [7:0] RST_POLARITY     = 8'h00;
  localparam logic [7:0] RST_BIAS_SMALL   = 8'h50;
  localparam logic [7:0] RST_DETECT       = 8'h30;
  localparam logic [7:0] RST_SPARE_B      = 8'h1A;
  localparam logic [7:0] RST_SPARE        = 8'h00;
  localparam logic [7:0] RST_BIAS_TRIM    = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED   = 8'h00;

  localparam int unsigned BIT_POL_INVERT  = 5;
  localparam int unsigned BIT_SMALL_BOOST = 3;
  localparam int unsigned BIT_QUICK_DET   = 6;
  localparam int unsigned BIT_THR_HI      = 5;
  localparam int unsigned BIT_THR_LO      = 4;
  localparam int unsigned BIT_EQB_HI      = 5;
  localparam int unsigned BIT_EQB_LO      = 4;
  localparam int unsigned BIT_PDRV_HI     = 3;
  localparam int unsigned BIT_PDRV_LO     = 2;
  localparam int unsigned BIT_ODRV_HI     = 1;
  localparam int unsigned BIT_ODRV_LO     = 0;

  localparam int unsigned READ_LATENCY    = 2;
  localparam int unsigned MEM_DEPTH       = 32;

  // Reserved locations kept in the spare memory
  function automatic logic is_spare(input logic [4:0] addr);
    is_spare = (addr == ADDR_SPARE_A) ||
               ((addr >= ADDR_SPARE_B) && (addr <= ADDR_SPARE_E)) ||
               (addr == ADDR_SPARE_F) ||
               ((addr >= ADDR_BLOCK_G_LO) && (addr <= ADDR_BLOCK_H_HI));
  endfunction

  function automatic logic [7:0] spare_reset(input logic [4:0] addr);
    spare_reset = (addr == ADDR_SPARE_B) ? RST_SPARE_B : RST_SPARE;
  endfunction

endpackage

// file: rtl/ccrx_spare_mem.sv
// Byte store for the reserved channel register locations.
// Ignores writes to addresses that are not spare locations; read data is registered.
module ccrx_spare_mem (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       wr_en,
  input  wire logic [4:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);

  logic [7:0] mem_reg   [ccrx_pkg::MEM_DEPTH];
  logic [7:0] mem_next  [ccrx_pkg::MEM_DEPTH];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    for (int i = 0; i < ccrx_pkg::MEM_DEPTH; i++) begin
      if (clear) begin
        mem_next[i] = ccrx_pkg::spare_reset(5'(i));
      end else if (wr_en && (addr == 5'(i)) &&
                   ccrx_pkg::is_spare(5'(i))) begin
        mem_next[i] = wdata;
      end else begin
        mem_next[i] = mem_reg[i];
      end
    end
    rdata_next = ccrx_pkg::is_spare(addr) ? mem_reg[addr]
                                          : ccrx_pkg::RDATA_UNMAPPED;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < ccrx_pkg::MEM_DEPTH; i++) begin
        mem_reg[i] <= (5'(i) == ccrx_pkg::ADDR_SPARE_B)
                      ? ccrx_pkg::RST_SPARE_B : ccrx_pkg::RST_SPARE;
      end
      rdata_reg <= ccrx_pkg::RST_SPARE;
    end else begin
      mem_reg   <= mem_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

endmodule // ccrx_spare_mem

// file: bench/ccrx_host_model.sv
// Register-port host model: single-byte writes and reads.
// Assumes requests launch just after a rising sys_clk edge.
module ccrx_host_model (
  input  wire logic       sys_clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [4:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 5'h00;
    reg_wdata = 8'h00;
  end

  // Released qualifiers go inverted, never left at the old value
  task automatic write_byte(input logic [4:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic read_byte(input logic [4:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
  endtask

  // Only field bits change; reserved bits keep their current value
  task automatic rmw_write(input logic [4:0] a, input logic [7:0] cur,
                           input logic [7:0] m, input logic [7:0] d,
                           output logic [7:0] sent);
    sent = (cur & ~m) | (d & m);
    write_byte(a, sent);
  endtask
endmodule // ccrx_host_model

// file: bench/ccrx_channel_regs_tb.sv
// Self-checking bench for two channel slices (pin a and pin b groups).
// Assumes the host model drives the register port; reads scoreboarded.
module ccrx_channel_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic       sys_clk, rst, regs_reset, pin_ctrl_enable;
  logic       output_source_select, eq_bias_ext_msb;
  logic       select_pin_a, select_pin_b;
  wire logic  reg_wr, reg_rd;
  wire logic [4:0] reg_addr;
  wire logic [7:0] reg_wdata;
  logic [7:0] rdata [2];
  logic       rvalid [2], route [2], inv [2], boost [2], quick [2];
  logic [1:0] thr [2], pdrv [2], odrv [2];
  logic [2:0] eqb [2];
  logic [7:0] sh [32];
  logic [7:0] exp_q [$];
  logic [7:0] mon_exp;
  int         bad_count, compares;

  ccrx_host_model ccrx_host_model_inst (.sys_clk(sys_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  for (genvar g = 0; g < 2; g++) begin : g_ch
    ccrx_channel_regs #(.CHAN_INDEX(g * 6)) ccrx_channel_regs_inst (
      .sys_clk(sys_clk), .rst(rst), .regs_reset(regs_reset),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(rdata[g]), .reg_rvalid(rvalid[g]),
      .pin_ctrl_enable(pin_ctrl_enable),
      .output_source_select(output_source_select),
      .eq_bias_ext_msb(eq_bias_ext_msb), .select_pin_a(select_pin_a),
      .select_pin_b(select_pin_b), .route_from_adjacent(route[g]),
      .xpoint_select_polarity_invert(inv[g]),
      .eq_bias_small_boost(boost[g]), .quick_detect_enable(quick[g]),
      .detect_threshold(thr[g]), .eq_bias_extra_current(eqb[g]),
      .predriver_bias_extra(pdrv[g]), .output_driver_bias_extra(odrv[g]));
  end

  always #10 sys_clk = ~sys_clk;

  task automatic check(input string n, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Scoreboard: oldest expected byte against each read answer
  always @(negedge sys_clk) begin
    if (rvalid[0] === 1'b1 || rvalid[1] === 1'b1) begin
      check("rvalid ch0", 8'(rvalid[0]), 8'h01);
      check("rvalid ch6", 8'(rvalid[1]), 8'h01);
      if (exp_q.size() == 0) begin
        check("unexpected read", 8'hFF, 8'h00);
      end else begin
        mon_exp = exp_q.pop_front();
        check("rdata ch0", rdata[0], mon_exp);
        check("rdata ch6", rdata[1], mon_exp);
      end
    end
  end

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    ccrx_host_model_inst.read_byte(a);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] m,
                    input logic [7:0] d);
    logic [7:0] s;
    ccrx_host_model_inst.rmw_write(a, sh[a], m, d, s);
    sh[a] = s;
  endtask

  function automatic logic [7:0] def_of(input logic [4:0] a);
    case (a)
      ccrx_pkg::ADDR_BIAS_SMALL: def_of = ccrx_pkg::RST_BIAS_SMALL;
      ccrx_pkg::ADDR_DETECT:     def_of = ccrx_pkg::RST_DETECT;
      ccrx_pkg::ADDR_SPARE_B:    def_of = ccrx_pkg::RST_SPARE_B;
      default:                   def_of = 8'h00;
    endcase
  endfunction

  task automatic chk_fields();
    for (int g = 0; g < 2; g++) begin
      check("invert", 8'(inv[g]), 8'(sh[7][5]));
      check("boost", 8'(boost[g]), 8'(sh[8][3]));
      check("quick", 8'(quick[g]), 8'(sh[10][6]));
      check("threshold", 8'(thr[g]), 8'(sh[10][5:4]));
      check("eq bias", 8'(eqb[g]), {5'h00, eq_bias_ext_msb, sh[15][5:4]});
      check("predriver", 8'(pdrv[g]), 8'(sh[15][3:2]));
      check("driver", 8'(odrv[g]), 8'(sh[15][1:0]));
    end
  endtask

  task automatic reset_check();
    for (int a = 0; a < 32; a++) begin
      sh[a] = def_of(5'(a));
      rd(5'(a), sh[a]);
    end
    settle(3);
    chk_fields();
  endtask

  task automatic chk_route(input logic e0, input logic e1);
    settle(8);
    check("route ch0", 8'(route[0]), 8'(e0));
    check("route ch6", 8'(route[1]), 8'(e1));
  endtask

  initial begin
    repeat (10000) @(posedge sys_clk);
    bad_count++;
    print_verdict();
  end

  initial begin
    logic [7:0] d;
    sys_clk = 1'b0;
    rst = 1'b1;
    regs_reset = 1'b0;
    pin_ctrl_enable = 1'b0;
    output_source_select = 1'b0;
    eq_bias_ext_msb = 1'b0;
    select_pin_a = 1'b0;
    select_pin_b = 1'b0;
    bad_count = 0;
    compares = 0;
    void'($urandom(32'hAF724FD6));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    reset_check();
    // Every field code first, then random values
    for (int k = 0; k < 16; k++) begin
      d = (k < 8) ? {2'b00, k[1:0], k[2:1], k[1:0]} : 8'($urandom);
      @(posedge sys_clk);
      eq_bias_ext_msb <= (k < 8) ? k[2] : d[7];
      wr(ccrx_pkg::ADDR_POLARITY, 8'h20, {2'b00, k[0], 5'h00} ^ d);
      wr(ccrx_pkg::ADDR_BIAS_SMALL, 8'h08, {4'h0, k[1], 3'h0} ^ d);
      wr(ccrx_pkg::ADDR_DETECT, 8'h70, {1'b0, k[0], k[2:1], 4'h0} ^ d);
      wr(ccrx_pkg::ADDR_BIAS_TRIM, 8'h3F, d);
      wr(ccrx_pkg::ADDR_SPARE_B, 8'h00, d);
      ccrx_host_model_inst.write_byte(5'h03, ~d);
      settle(3);
      chk_fields();
      rd(ccrx_pkg::ADDR_DETECT, sh[10]);
      rd(ccrx_pkg::ADDR_BIAS_TRIM, sh[15]);
      rd(ccrx_pkg::ADDR_SPARE_B, sh[11]);
      rd(5'h03, ccrx_pkg::RDATA_UNMAPPED);
    end
    // Channel register reset swallows a write in the same cycle
    fork
      ccrx_host_model_inst.write_byte(ccrx_pkg::ADDR_BIAS_TRIM, 8'h3F);
      begin
        @(posedge sys_clk);
        regs_reset <= 1'b1;
        @(posedge sys_clk);
        regs_reset <= 1'b0;
      end
    join
    reset_check();
    // Register control: invert and pins have no say
    wr(ccrx_pkg::ADDR_POLARITY, 8'h20, 8'h20);
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      output_source_select <= s[0];
      select_pin_a <= ~s[0];
      select_pin_b <= s[0];
      chk_route(s[0], s[0]);
    end
    // Pin control: pin a for channel 0, pin b for channel 6
    for (int v = 0; v < 2; v++) begin
      wr(ccrx_pkg::ADDR_POLARITY, 8'h20, {2'b00, v[0], 5'h00});
      for (int p = 0; p < 4; p++) begin
        @(posedge sys_clk);
        pin_ctrl_enable <= 1'b1;
        output_source_select <= ~p[0];
        select_pin_a <= p[0];
        select_pin_b <= p[1];
        chk_route(p[0] ^ v[0], p[1] ^ v[0]);
      end
    end
    // Second reset in mid-run
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    reset_check();
    settle(4);
    check("reads left", 8'(exp_q.size()), 8'h00);
    print_verdict();
  end
endmodule // ccrx_channel_regs_tb
